// file: asb_pkg.sv
// constants and types for the alarm status and tone register bank
package asb_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_BANK_SEL = 8'h4e;
	localparam logic [7:0] IDX_FORCE = 8'h53;
	localparam logic [7:0] IDX_STAT_ONE = 8'h59;
	localparam logic [7:0] IDX_STAT_TWO = 8'h5a;
	localparam logic [7:0] IDX_TONE_EN = 8'h60;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h61;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
	localparam logic [7:0] IDX_BANKED_LO = 8'h50;
	localparam logic [7:0] IDX_BANKED_HI = 8'h5f;
	localparam logic [2:0] BANK_ALARM = 3'h4;

	// ==========================================================
	// field positions
	localparam int FORCE_BIT = 5;
	localparam int HBYTE_BIT = 7;
	localparam int TONE_EN_BIT = 0;
	localparam int STAT_ONE_W = 8;
	localparam int STAT_TWO_W = 4;
	localparam int IRQ_W = 16;
	localparam logic [7:0] STAT_ONE_MASK = 8'hfd;

	// ==========================================================
	// reset values
	localparam logic [2:0] RST_BANK = 3'h0;
	localparam logic RST_HBYTE = 1'b1;
	localparam logic [7:0] RST_FORCE = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h00;
	localparam logic RST_TONE_EN = 1'b1;
	localparam logic [15:0] RST_IRQ = 16'h0000;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// ==========================================================
	// register selection
	typedef enum logic [2:0] {
		REG_NONE = 3'b000,
		REG_BANK_SEL = 3'b001,
		REG_FORCE = 3'b010,
		REG_STAT_ONE = 3'b011,
		REG_STAT_TWO = 3'b100,
		REG_TONE_EN = 3'b101,
		REG_IRQ_STAT = 3'b110,
		REG_IRQ_MASK = 3'b111
	} asb_reg_t;

endpackage : asb_pkg

// file: asb_sync.sv
// two-flop synchroniser for level flags from the limit comparators
`timescale 1ns/1ns

module asb_sync #(
	parameter int WIDTH = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} asb_sync_t;

	asb_sync_t s_ff;
	asb_sync_t nxt_s;

	// meta stage feeds only the second stage
	always_comb begin
		nxt_s.meta = async_in;
		nxt_s.sync = s_ff.meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sync_out = s_ff.sync;

endmodule : asb_sync

// file: asb_regs.sv
// alarm status, forced tone and interrupt registers behind an AHB-Lite slave
`timescale 1ns/1ns

// Functional notes
// RULE1: force bit 5 set drives the alarm tone continuously; clear has no effect
// RULE2: force and both status registers are 8 bits, zero after reset
// RULE3: status one bits 7,6 show fan two and fan one out of limit
// RULE4: status one bits 5,4 show temperature one and two out of limit
// RULE5: status one bits 3,2,0 show +5V, +3.3V, core supply; bit 1 reserved
// RULE6: status two bits 3..0: fan three, -5V, -12V, +12V; 7..4 reserved
// RULE7: status registers are read only; host writes are ignored
// RULE8: status bits follow the comparison live; reading does not clear
// RULE9: master tone enable, default 1, when 0 silences every tone source
// RULE10: indices 0x50..0x5F answer only while bank select holds 4
module asb_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] over_limit_one,
	input wire logic [3:0] over_limit_two,
	input wire logic alarm_source,
	output logic alarm_tone_output,
	output logic irq
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [2:0] bank;
		logic hbyte;
		logic [7:0] force_reg;
		logic [7:0] stat_one;
		logic [7:0] stat_two;
		logic tone_en;
		logic [15:0] irq_stat;
		logic [15:0] irq_mask;
		logic wr_pend;
		logic wr_hit;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic readyout;
		logic resp;
		logic tone;
		logic irq;
	} asb_state_t;

	asb_state_t s_ff;
	asb_state_t nxt_s;
	logic [11:0] flags_sync;
	logic [15:0] events;
	logic addr_hit;
	logic take;
	asb_pkg::asb_reg_t rd_sel;
	asb_pkg::asb_reg_t wr_sel;

	// ==========================================================
	// comparator flags arrive from another timing domain
	asb_sync #(
		.WIDTH(12)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({over_limit_two, over_limit_one}),
		.sync_out(flags_sync)
	);

	// ==========================================================
	// address decode, shared by the read and the write paths
	function automatic asb_pkg::asb_reg_t asb_decode(
		input logic hit,
		input logic [7:0] idx,
		input logic [2:0] bank
	);
		logic banked;
		banked = (idx >= asb_pkg::IDX_BANKED_LO) &&
			(idx <= asb_pkg::IDX_BANKED_HI);
		asb_decode = asb_pkg::REG_NONE;
		if (hit && !(banked && bank != asb_pkg::BANK_ALARM)) begin // [RULE10]
			case (idx)
				asb_pkg::IDX_BANK_SEL: asb_decode = asb_pkg::REG_BANK_SEL;
				asb_pkg::IDX_FORCE: asb_decode = asb_pkg::REG_FORCE;
				asb_pkg::IDX_STAT_ONE: asb_decode = asb_pkg::REG_STAT_ONE;
				asb_pkg::IDX_STAT_TWO: asb_decode = asb_pkg::REG_STAT_TWO;
				asb_pkg::IDX_TONE_EN: asb_decode = asb_pkg::REG_TONE_EN;
				asb_pkg::IDX_IRQ_STAT: asb_decode = asb_pkg::REG_IRQ_STAT;
				asb_pkg::IDX_IRQ_MASK: asb_decode = asb_pkg::REG_IRQ_MASK;
				default: asb_decode = asb_pkg::REG_NONE;
			endcase
		end
	endfunction : asb_decode

	// only aligned words in the low kilobyte are mapped
	assign addr_hit = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
	assign take = hsel && htrans[1] && hready;
	assign wr_sel = asb_decode(s_ff.wr_hit, s_ff.wr_idx, s_ff.bank);

	// ==========================================================
	// next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wr_pend = 1'b0;
		nxt_s.readyout = 1'b1;
		nxt_s.resp = 1'b0;
		rd_sel = asb_pkg::REG_NONE;

		// data phase of a write; status registers have no write arm
		if (s_ff.wr_pend) begin
			unique case (wr_sel)
				asb_pkg::REG_BANK_SEL: begin
					nxt_s.bank = hwdata[2:0]; // [RULE10]
					nxt_s.hbyte = hwdata[asb_pkg::HBYTE_BIT];
				end
				asb_pkg::REG_FORCE: begin
					nxt_s.force_reg = 8'h00;
					nxt_s.force_reg[asb_pkg::FORCE_BIT] =
						hwdata[asb_pkg::FORCE_BIT]; // [RULE1]
				end
				asb_pkg::REG_TONE_EN: begin
					nxt_s.tone_en = hwdata[asb_pkg::TONE_EN_BIT]; // [RULE9]
				end
				asb_pkg::REG_IRQ_MASK: begin
					nxt_s.irq_mask = hwdata[15:0];
				end
				asb_pkg::REG_NONE, asb_pkg::REG_STAT_ONE,
				asb_pkg::REG_STAT_TWO, asb_pkg::REG_IRQ_STAT: begin
					nxt_s.wr_pend = 1'b0; // [RULE7]
				end
			endcase
		end

		// status follows the comparators, never latched by reads
		nxt_s.stat_one = flags_sync[7:0] & asb_pkg::STAT_ONE_MASK; // [RULE3] [RULE4] [RULE5] [RULE8]
		nxt_s.stat_two = {4'h0, flags_sync[11:8]}; // [RULE6] [RULE8]

		// a new out-of-limit condition is an interrupt event
		events = {nxt_s.stat_two & ~s_ff.stat_two,
			nxt_s.stat_one & ~s_ff.stat_one};

		// address phase; read data sees a write completing this cycle
		if (take) begin
			if (hwrite) begin
				nxt_s.wr_pend = 1'b1;
				nxt_s.wr_hit = addr_hit;
				nxt_s.wr_idx = haddr[9:2];
				nxt_s.rdata = asb_pkg::RST_RDATA;
			end else begin
				rd_sel = asb_decode(addr_hit, haddr[9:2], nxt_s.bank);
				nxt_s.rdata = asb_pkg::RST_RDATA;
				unique case (rd_sel)
					asb_pkg::REG_BANK_SEL: begin
						nxt_s.rdata[7:0] = {nxt_s.hbyte, 4'h0, nxt_s.bank};
					end
					asb_pkg::REG_FORCE: begin
						nxt_s.rdata[7:0] = nxt_s.force_reg;
					end
					asb_pkg::REG_STAT_ONE: begin
						nxt_s.rdata[7:0] = nxt_s.stat_one; // [RULE8]
					end
					asb_pkg::REG_STAT_TWO: begin
						nxt_s.rdata[7:0] = nxt_s.stat_two; // [RULE8]
					end
					asb_pkg::REG_TONE_EN: begin
						nxt_s.rdata[0] = nxt_s.tone_en;
					end
					asb_pkg::REG_IRQ_STAT: begin
						nxt_s.rdata[15:0] = s_ff.irq_stat;
					end
					asb_pkg::REG_IRQ_MASK: begin
						nxt_s.rdata[15:0] = nxt_s.irq_mask;
					end
					asb_pkg::REG_NONE: begin
						nxt_s.rdata = asb_pkg::RST_RDATA;
					end
				endcase
			end
		end

		// read clears what it returned; an event in the same cycle wins
		if (rd_sel == asb_pkg::REG_IRQ_STAT) begin
			nxt_s.irq_stat = events;
		end else begin
			nxt_s.irq_stat = s_ff.irq_stat | events;
		end
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);

		// master enable gates the force override and every other source
		nxt_s.tone = s_ff.tone_en &&
			(s_ff.force_reg[asb_pkg::FORCE_BIT] || alarm_source); // [RULE1] [RULE9]
	end

	// ==========================================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff.bank <= asb_pkg::RST_BANK;
			s_ff.hbyte <= asb_pkg::RST_HBYTE;
			s_ff.force_reg <= asb_pkg::RST_FORCE; // [RULE2]
			s_ff.stat_one <= asb_pkg::RST_STAT; // [RULE2]
			s_ff.stat_two <= asb_pkg::RST_STAT; // [RULE2]
			s_ff.tone_en <= asb_pkg::RST_TONE_EN; // [RULE9]
			s_ff.irq_stat <= asb_pkg::RST_IRQ;
			s_ff.irq_mask <= asb_pkg::RST_IRQ;
			s_ff.wr_pend <= 1'b0;
			s_ff.wr_hit <= 1'b0;
			s_ff.wr_idx <= 8'h00;
			s_ff.rdata <= asb_pkg::RST_RDATA;
			s_ff.readyout <= 1'b1;
			s_ff.resp <= 1'b0;
			s_ff.tone <= 1'b0;
			s_ff.irq <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hrdata = s_ff.rdata;
	assign hreadyout = s_ff.readyout;
	assign hresp = s_ff.resp;
	assign alarm_tone_output = s_ff.tone;
	assign irq = s_ff.irq;

	// ==========================================================
	// assertions
	// status checks compare with the synchronised flags one edge earlier
	a_force_tone_on: assert property ( // [RULE1]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.tone_en && s_ff.force_reg[asb_pkg::FORCE_BIT])
		|=> alarm_tone_output
	) else $error("forced tone not driven");

	a_reset_values: assert property ( // [RULE2]
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (s_ff.force_reg == 8'h00 &&
		s_ff.stat_one == 8'h00 && s_ff.stat_two == 8'h00)
	) else $error("registers not zero after reset");

	a_fan_status: assert property ( // [RULE3]
		@(posedge hclk) disable iff (!hresetn)
		s_ff.stat_one[7:6] == $past(flags_sync[7:6])
	) else $error("fan status does not follow flags");

	a_temp_status: assert property ( // [RULE4]
		@(posedge hclk) disable iff (!hresetn)
		$rose(flags_sync[5]) |=> s_ff.stat_one[5] && !$past(s_ff.stat_one[5])
	) else $error("temperature one status missed");

	a_volt_status: assert property ( // [RULE5]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.stat_one[1] == 1'b0) &&
		(s_ff.stat_one[3:2] == $past(flags_sync[3:2])) &&
		(s_ff.stat_one[0] == $past(flags_sync[0]))
	) else $error("voltage status wrong");

	a_status_two: assert property ( // [RULE6]
		@(posedge hclk) disable iff (!hresetn)
		s_ff.stat_two == {4'h0, $past(flags_sync[11:8])}
	) else $error("status two wrong");

	a_status_ro: assert property ( // [RULE7]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.wr_pend && wr_sel == asb_pkg::REG_STAT_ONE && !flags_sync[7])
		|=> !s_ff.stat_one[7]
	) else $error("status written by host");

	a_read_noclear: assert property ( // [RULE8]
		@(posedge hclk) disable iff (!hresetn)
		(rd_sel == asb_pkg::REG_STAT_ONE && flags_sync[6])
		|=> s_ff.stat_one[6] && s_ff.rdata[6]
	) else $error("status read cleared or wrong");

	a_master_mute: assert property ( // [RULE9]
		@(posedge hclk) disable iff (!hresetn)
		!s_ff.tone_en |=> !alarm_tone_output
	) else $error("tone with master enable clear");

	a_bank_gate: assert property ( // [RULE10]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.wr_pend && s_ff.wr_idx == asb_pkg::IDX_FORCE &&
		s_ff.bank != asb_pkg::BANK_ALARM) |=> $stable(s_ff.force_reg)
	) else $error("banked write taken in wrong bank");

	a_force_write: assert property ( // [RULE1]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.wr_pend && wr_sel == asb_pkg::REG_FORCE)
		|=> (s_ff.force_reg[asb_pkg::FORCE_BIT] ==
		$past(hwdata[asb_pkg::FORCE_BIT])) &&
		((s_ff.force_reg & 8'hdf) == 8'h00)
	) else $error("force register stored wrong bits");

	a_force_hold: assert property ( // [RULE1]
		@(posedge hclk) disable iff (!hresetn)
		!(s_ff.wr_pend && wr_sel == asb_pkg::REG_FORCE)
		|=> $stable(s_ff.force_reg)
	) else $error("force register changed without a write");

	a_tone_source: assert property ( // [RULE9]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.tone_en && alarm_source) |=> alarm_tone_output
	) else $error("enabled tone source not driven");

	a_tone_off: assert property ( // [RULE1]
		@(posedge hclk) disable iff (!hresetn)
		(!s_ff.force_reg[asb_pkg::FORCE_BIT] && !alarm_source)
		|=> !alarm_tone_output
	) else $error("tone without any source");

	a_bank_read: assert property ( // [RULE10]
		@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && rd_sel == asb_pkg::REG_NONE)
		|=> (hrdata == 32'h0000_0000)
	) else $error("refused read returned data");

	a_bank_write: assert property ( // [RULE10]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.wr_pend && wr_sel == asb_pkg::REG_BANK_SEL)
		|=> (s_ff.bank == $past(hwdata[2:0]))
	) else $error("bank select not stored");

	a_temp_two: assert property ( // [RULE4]
		@(posedge hclk) disable iff (!hresetn)
		s_ff.stat_one[4] == $past(flags_sync[4])
	) else $error("temperature two status wrong");

	a_stat_two_ro: assert property ( // [RULE7]
		@(posedge hclk) disable iff (!hresetn)
		(s_ff.wr_pend && wr_sel == asb_pkg::REG_STAT_TWO)
		|=> (s_ff.stat_two == {4'h0, $past(flags_sync[11:8])})
	) else $error("status two written by host");

	a_read_two: assert property ( // [RULE8]
		@(posedge hclk) disable iff (!hresetn)
		(rd_sel == asb_pkg::REG_STAT_TWO)
		|=> (s_ff.rdata[7:0] == s_ff.stat_two)
	) else $error("status two read wrong");

endmodule : asb_regs

// file: asb_host.sv
// host-side AHB-Lite master model for the alarm register bank
`timescale 1ns/1ns

module asb_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
	end

	// ==========================================================
	// bounded wait for hready, sampled at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 20) begin
				test_asb_regs.fail_count++;
				test_asb_regs.wrap_up();
			end
			@(posedge hclk);
		end
	endtask : wait_ready

	// ==========================================================
	// one single word transfer; the register sits at four times its index
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h00_0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		hsel <= 1'b0;
		// released data lines must not keep the last value
		hwdata <= ~d;
	endtask : xfer
endmodule : asb_host

// file: test_asb_regs.sv
// self-checking bench for the alarm status and tone register bank
`timescale 1ns/1ns

module test_asb_regs;
	logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, tone, irq, src;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] lim1;
	logic [3:0] lim2;
	logic [7:0] pat1 [4] = '{8'hff, 8'ha5, 8'h5a, 8'h00};
	logic [3:0] pat2 [4] = '{4'hf, 4'h5, 4'ha, 4'h0};
	int fail_count, checked;

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	asb_host asb_host_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	asb_regs asb_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .over_limit_one(lim1),
		.over_limit_two(lim2), .alarm_source(src),
		.alarm_tone_output(tone), .irq(irq));

	// ==========================================================
	// comparisons and bus helpers
	task automatic chk_reg(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg

	task automatic chk_pin(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_pin

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		asb_host_inst.xfer(1'b1, idx, d, q);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] idx,
		input logic [31:0] exp);
		logic [31:0] got;
		asb_host_inst.xfer(1'b0, idx, 32'h0000_0000, got);
		chk_reg(what, exp, got);
	endtask : rd_chk

	// let the edge's updates land before pins are looked at
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : idle

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		src = 1'b0;
		lim1 = 8'h00;
		lim2 = 4'h0;
		fail_count = 0;
		checked = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		idle(1);
		chk_pin("tone", 1'b0, tone);
		rd_chk("bank", asb_pkg::IDX_BANK_SEL, 32'h0000_0080);
		rd_chk("tone_en", asb_pkg::IDX_TONE_EN, 32'h0000_0001);
		lim1 <= 8'hff;
		idle(5);
		rd_chk("stat1 bank0", asb_pkg::IDX_STAT_ONE, 32'h0000_0000);
		rd_chk("unmapped", 8'hff, 32'h0000_0000);
		wr(asb_pkg::IDX_FORCE, 32'h0000_00ff);
		wr(asb_pkg::IDX_BANK_SEL, 32'h0000_0004);
		rd_chk("bank4", asb_pkg::IDX_BANK_SEL, 32'h0000_0004);
		rd_chk("force", asb_pkg::IDX_FORCE, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			lim1 <= pat1[i];
			lim2 <= pat2[i];
			idle(5);
			rd_chk("stat1", asb_pkg::IDX_STAT_ONE, {24'h0, pat1[i] & 8'hfd});
			wr(asb_pkg::IDX_STAT_ONE, {24'h0, ~pat1[i]});
			rd_chk("stat1 again", asb_pkg::IDX_STAT_ONE, {24'h0, pat1[i] & 8'hfd});
			wr(asb_pkg::IDX_STAT_TWO, 32'h0000_00ff);
			rd_chk("stat2", asb_pkg::IDX_STAT_TWO, {28'h0, pat2[i]});
		end
		wr(asb_pkg::IDX_FORCE, 32'h0000_00ff);
		rd_chk("force", asb_pkg::IDX_FORCE, 32'h0000_0020);
		idle(2);
		chk_pin("tone forced", 1'b1, tone);
		wr(asb_pkg::IDX_TONE_EN, 32'h0000_0000);
		src <= 1'b1;
		idle(2);
		chk_pin("tone gated", 1'b0, tone);
		wr(asb_pkg::IDX_TONE_EN, 32'h0000_0001);
		wr(asb_pkg::IDX_FORCE, 32'h0000_0000);
		idle(2);
		chk_pin("tone source", 1'b1, tone);
		@(posedge hclk);
		src <= 1'b0;
		idle(2);
		chk_pin("tone off", 1'b0, tone);
		chk_pin("hresp", 1'b0, hresp);
		chk_pin("hreadyout", 1'b1, hreadyout);
		// rises seen so far: fd from ff and f on status two; 5a after a5 adds no new bit
		rd_chk("irq stat", asb_pkg::IDX_IRQ_STAT, 32'h0000_0ffd);
		rd_chk("irq cleared", asb_pkg::IDX_IRQ_STAT, 32'h0000_0000);
		wr(asb_pkg::IDX_IRQ_MASK, 32'h0000_0001);
		rd_chk("irq mask", asb_pkg::IDX_IRQ_MASK, 32'h0000_0001);
		lim1 <= 8'h01;
		idle(5);
		chk_pin("irq", 1'b1, irq);
		rd_chk("irq stat bit0", asb_pkg::IDX_IRQ_STAT, 32'h0000_0001);
		idle(1);
		chk_pin("irq after read", 1'b0, irq);
		@(posedge hclk);
		lim1 <= 8'h04;
		idle(5);
		chk_pin("irq masked", 1'b0, irq);
		wrap_up();
	end
endmodule : test_asb_regs
